/* File: hw/dic_top.sv */
// Duplex playback DMA channel, DRQ latch and interrupt routing logic.
`timescale 1ns/10ps
module dic_top import dic_pkg::*; #(
   parameter int MS_CYCLES = DIC_MS_CYCLES,
   parameter int FIFO_DEPTH = 32
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic soft_reset,
   input wire logic audio1_event,
   input wire logic vol_button_event,
   input wire logic midi_rx_avail,
   input wire logic optical_drive_irq_in,
   input wire logic modem_irq_in,
   input wire logic modem_irq_disable_in,
   input wire logic general_purpose_input,
   input wire logic gpi_is_drq,
   input wire logic cfg_hdr_load,
   input wire logic [23:0] cfg_hdr_irq_chan,
   input wire logic [2:0] drq_raw_in,
   input wire logic [2:0] dack_n_in,
   input wire logic [7:0] isa_data_in,
   input wire logic sample_tick,
   output logic [2:0] drq_out,
   output logic [15:0] dac_word_q,
   output dic_irqpin_s irq_pins
);
   //=======================================================================
   // Pin synchronisers.
   localparam int SW = 15;
   logic [SW-1:0] pin_a_q, pin_b_q;
   wire [SW-1:0] pin_raw = {isa_data_in, dack_n_in, general_purpose_input,
      modem_irq_disable_in, modem_irq_in, optical_drive_irq_in};
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pin_a_q <= '1;
         pin_b_q <= '1;
      end else begin
         pin_a_q <= pin_raw;
         pin_b_q <= pin_a_q;
      end
   end
   wire cd_pin = pin_b_q[0];
   wire mdm_pin = pin_b_q[1];
   wire mdm_dis = pin_b_q[2];
   wire gp_pin = pin_b_q[3];
   wire [2:0] dack_n = pin_b_q[6:4];
   wire [7:0] isa_data = pin_b_q[14:7];
   logic [2:0] dack_n_q;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) dack_n_q <= '1;
      else dack_n_q <= dack_n;
   end
   // A DACK low pulse is seen at its falling edge.
   wire [2:0] dack_fall = dack_n_q & ~dack_n;

   //=======================================================================
   // Avalon slave: one wait state, then the answer.
   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   wire req = avs_read | avs_write;
   wire wr = avs_write & ack_q;
   wire rd = avs_read & ack_q;
   assign avs_waitrequest = req & ~ack_q;
   assign avs_readdata = rdata_q;
   wire [7:0] wd = avs_writedata[7:0];
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ack_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q <= req & ~ack_q;
         rdata_q <= rdata_d;
      end
   end

   //=======================================================================
   // Software registers.
   logic [6:0] src_mask_q;
   logic [7:0] reload_lo_q, reload_hi_q, ctl1_q, volume_q, latch_cfg_q;
   logic [7:0] irq_chan_q [3];
   logic [2:0] route_q [DIC_NSRC];
   dic_active_s active_q;
   logic ctl2_mask_q;
   wire a_hit_mask = avs_address == DIC_SRC_MASK;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         src_mask_q <= DIC_SRC_MASK_RST;
         reload_lo_q <= '0;
         reload_hi_q <= '0;
         ctl1_q <= '0;
         volume_q <= '0;
         latch_cfg_q <= '0;
         active_q <= '0;
         ctl2_mask_q <= 1'b0;
         for (int i = 0; i < 3; i++) irq_chan_q[i] <= '0;
         for (int i = 0; i < DIC_NSRC; i++) route_q[i] <= '0;
      end else begin
         if (wr && a_hit_mask) src_mask_q <= wd[6:0];
         if (wr && avs_address == DIC_RELOAD_LO) reload_lo_q <= wd;
         if (wr && avs_address == DIC_RELOAD_HI) reload_hi_q <= wd;
         if (wr && avs_address == DIC_CTL1) ctl1_q <= wd;
         if (wr && avs_address == DIC_CTL2) ctl2_mask_q <= wd[DIC_CTL2_MASK];
         if (wr && avs_address == DIC_VOLUME) volume_q <= wd;
         if (wr && avs_address == DIC_LATCH_CFG) latch_cfg_q <= wd;
         if (wr && avs_address == DIC_ACTIVATE) active_q <= wd[3:0];
         for (int i = 0; i < 3; i++) begin
            if (cfg_hdr_load) begin
               irq_chan_q[i] <= cfg_hdr_irq_chan[8*i +: 8];
            end else if (wr && avs_address == DIC_IRQ_CHAN0 + 8'(i)) begin
               irq_chan_q[i] <= wd;
            end
         end
         for (int i = 0; i < DIC_NSRC; i++) begin
            if (wr && avs_address == DIC_ROUTE0 + 8'(i)) route_q[i] <= wd[2:0];
         end
      end
   end
   wire fd_mode = ctl1_q[DIC_CTL1_FD];
   wire pb_en = ctl1_q[DIC_CTL1_EN];
   wire auto_init = ctl1_q[DIC_CTL1_AUTO];

   //=======================================================================
   // Playback FIFO of 16-bit words built from byte pairs, low byte first.
   localparam int PW = $clog2(FIFO_DEPTH);
   logic [15:0] fifo_mem [FIFO_DEPTH];
   logic [PW-1:0] wp_q, rp_q;
   logic [PW:0] fcnt_q;
   logic [7:0] low_byte_q;
   logic half_q;
   wire byte_take = dack_fall[1] & pb_en;
   wire push = byte_take & half_q;
   wire pop = sample_tick & fd_mode & (fcnt_q != '0);
   wire fifo_full = fcnt_q == (PW+1)'(FIFO_DEPTH);
   always_ff @(posedge sys_clk) begin
      if (push) fifo_mem[wp_q] <= {isa_data, low_byte_q};
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wp_q <= '0;
         rp_q <= '0;
         fcnt_q <= '0;
         low_byte_q <= '0;
         half_q <= 1'b0;
         dac_word_q <= '0;
      end else begin
         if (byte_take) begin
            half_q <= ~half_q;
            if (!half_q) low_byte_q <= isa_data;
         end
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         fcnt_q <= fcnt_q + (PW+1)'(push) - (PW+1)'(pop);
         if (sample_tick && fd_mode) begin
            dac_word_q <= pop ? fifo_mem[rp_q] : 16'h0000;
         end
         if (!fd_mode && !pb_en) begin
            wp_q <= '0;
            rp_q <= '0;
            fcnt_q <= '0;
            half_q <= 1'b0;
         end
      end
   end

   //=======================================================================
   // Transfer counter: counts bytes up from the two's complement reload.
   logic [15:0] count_q;
   logic done_q, pb_irq_q, pb_en_q;
   wire [15:0] count_inc = count_q + 16'h0001;
   wire rollover = byte_take & (count_inc == 16'h0000);
   wire reload_wr = wr & (avs_address == DIC_RELOAD_HI);
   wire irq_clr = wr & (avs_address == DIC_CTL2) & ~wd[DIC_CTL2_IRQ];
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         count_q <= '0;
         done_q <= 1'b0;
         pb_irq_q <= 1'b0;
         pb_en_q <= 1'b0;
      end else begin
         pb_en_q <= pb_en;
         // A high byte write loads the new byte, not the stale register.
         if (reload_wr) begin
            count_q <= {wd, reload_lo_q};
            done_q <= 1'b0;
         end else if (pb_en && !pb_en_q) begin
            count_q <= {reload_hi_q, reload_lo_q};
            done_q <= 1'b0;
         end else if (rollover && auto_init) begin
            count_q <= {reload_hi_q, reload_lo_q};
         end else if (rollover) begin
            count_q <= count_inc;
            done_q <= 1'b1;
         end else if (byte_take) begin
            count_q <= count_inc;
         end
         // A rollover in the clearing cycle still sets the request.
         if (rollover) pb_irq_q <= 1'b1;
         else if (irq_clr) pb_irq_q <= 1'b0;
      end
   end
   // Request stays up until the FIFO holds FIFO_DEPTH words or done_q is set; the held low byte is not counted.
   wire pb_drq = pb_en & ~done_q & ~fifo_full;

   //=======================================================================
   // DRQ latch with 1 ms tick timer.
   logic [$clog2(MS_CYCLES+1)-1:0] ms_cnt_q;
   logic ms_tick_q;
   logic [2:0] latch_q;
   logic [3:0] idle_ms_q [3];
   wire latch_on = latch_cfg_q[DIC_LATCH_EN];
   wire [2:0] drq_int = {drq_raw_in[2], pb_drq, drq_raw_in[0]};
   // The counter wraps on the same compare that raises the tick.
   wire ms_wrap = ms_cnt_q == $bits(ms_cnt_q)'(MS_CYCLES - 1);
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ms_cnt_q <= '0;
         ms_tick_q <= 1'b0;
         latch_q <= '0;
         for (int i = 0; i < 3; i++) idle_ms_q[i] <= '0;
      end else begin
         ms_tick_q <= ms_wrap;
         ms_cnt_q <= ms_wrap ? '0 : ms_cnt_q + 1'b1;
         for (int i = 0; i < 3; i++) begin
            if (!latch_on || drq_int[i]) begin
               idle_ms_q[i] <= '0;
               latch_q[i] <= latch_on & drq_int[i];
            end else if (dack_fall[i]) begin
               latch_q[i] <= 1'b0;
            end else if (ms_tick_q && latch_q[i]) begin
               // Nine ticks give at least eight full milliseconds.
               if (idle_ms_q[i] == 4'(DIC_LATCH_MS)) latch_q[i] <= 1'b0;
               idle_ms_q[i] <= idle_ms_q[i] + 4'h1;
            end
         end
      end
   end
   assign drq_out = drq_int | latch_q;

   //=======================================================================
   // Sticky interrupt sources: audio one and hardware volume.
   logic a1_irq_q, vol_irq_q;
   wire a1_clr = rd & (avs_address == DIC_A1_CLEAR);
   wire vol_clr = wr & (avs_address == DIC_VOL_CLEAR);
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         a1_irq_q <= 1'b0;
         vol_irq_q <= 1'b0;
      end else begin
         if (audio1_event) a1_irq_q <= 1'b1;
         else if (a1_clr || soft_reset) a1_irq_q <= 1'b0;
         if (vol_button_event) vol_irq_q <= 1'b1;
         else if (vol_clr) vol_irq_q <= 1'b0;
      end
   end

   //=======================================================================
   // Source gating, status and pin routing.
   wire gp_src = gp_pin & ~gpi_is_drq;
   wire [6:0] src_gated = {
      gp_src,
      mdm_pin & ~mdm_dis,
      cd_pin,
      midi_rx_avail & volume_q[DIC_MIDI_MASK],
      vol_irq_q & volume_q[DIC_VOL_MASK],
      pb_irq_q & ctl2_mask_q,
      a1_irq_q};
   // Status reads the sources before the source mask register.
   wire [7:0] status_val = {1'b0, src_gated};
   wire [6:0] src_final = src_gated & src_mask_q;
   wire [6:0] src_active = {active_q.gp,
      active_q.modem & ~mdm_dis, active_q.cd,
      {4{active_q.audio}}};
   logic [4:0] pin_lvl, pin_oe;
   always_comb begin
      pin_lvl = '0;
      pin_oe = '0;
      for (int s = 0; s < DIC_NSRC; s++) begin
         for (int p = 0; p < DIC_NPIN; p++) begin
            if (route_q[s] == 3'(p + 1)) begin
               pin_lvl[p] = pin_lvl[p] | (src_final[s] & src_active[s]);
               pin_oe[p] = pin_oe[p] | src_active[s];
            end
         end
      end
   end
   dic_irqpin_s pins_q;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) pins_q <= '0;
      else pins_q <= '{level: pin_lvl, oe: pin_oe};
   end
   assign irq_pins = pins_q;

   //=======================================================================
   // Read data decode.
   wire [7:0] a = avs_address;
   always_comb begin
      rdata_d = '0;
      if (a == DIC_STATUS) rdata_d[7:0] = status_val;
      else if (a == DIC_SRC_MASK) rdata_d[6:0] = src_mask_q;
      else if (a == DIC_A1_POLL) rdata_d[0] = a1_irq_q;
      else if (a == DIC_A1_CLEAR) rdata_d[0] = a1_irq_q;
      else if (a >= DIC_IRQ_CHAN0 && a < DIC_IRQ_CHAN0 + 8'h03)
         rdata_d[7:0] = irq_chan_q[2'(a - DIC_IRQ_CHAN0)];
      else if (a == DIC_LATCH_CFG) rdata_d[7:0] = latch_cfg_q;
      else if (a == DIC_ACTIVATE) rdata_d[3:0] = active_q;
      else if (a == DIC_VOLUME) begin
         rdata_d[7:0] = volume_q;
         rdata_d[DIC_VOL_POLL] = vol_irq_q;
      end else if (a == DIC_RELOAD_LO) rdata_d[7:0] = reload_lo_q;
      else if (a == DIC_RELOAD_HI) rdata_d[7:0] = reload_hi_q;
      else if (a == DIC_CTL1) rdata_d[7:0] = ctl1_q;
      else if (a == DIC_CTL2) begin
         rdata_d[DIC_CTL2_IRQ] = pb_irq_q;
         rdata_d[DIC_CTL2_MASK] = ctl2_mask_q;
      end else if (a >= DIC_ROUTE0 && a < DIC_ROUTE0 + 8'h07)
         rdata_d[2:0] = route_q[3'(a - DIC_ROUTE0)];
   end
endmodule

/* File: hw/dic_pkg.sv */
// Package of constants and types for the duplex DMA and interrupt block.
//==========================================================================
// Overview of operation
// - Playback reload count held as two bytes
// - Auto-initialize reloads counter on rollover to zero
// - Playback rollover raises its own interrupt
// - Playback FIFO of thirty-two words filled by DMA
// - Control one bit 0 enables full duplex
// - Control one bit 1 enables playback DMA
// - Empty FIFO sends zero at sample clock
// - Control two bit 7 holds playback request
// - Control two bit 6 masks playback interrupt
// - DRQ latch active when latch bit set
// - Latched DRQ released by ack, reset, timeout
// - Audio one request cleared by resets, read
// - Volume interrupt raised, masked, polled, cleared
// - MIDI interrupt follows receive data flag
// - Pins are sources; GENERAL_PURPOSE_INPUT blocked when DRQ
// - Any source routes to one of five pins
// - Pin channel numbers loaded from config header
// - Pin drives when an assigned source active
// - Request ANDed with all its masks
// - Status register reports gated source requests
// - Both channels share first channel sample rate
// - Source mask register resets to all ones
// - Status ignores the source mask register
package dic_pkg;
   //=======================================================================
   // Register indices; byte address is four times the index.
   localparam logic [7:0] DIC_STATUS = 8'h06;
   localparam logic [7:0] DIC_SRC_MASK = 8'h07;
   localparam logic [7:0] DIC_A1_POLL = 8'h0C;
   localparam logic [7:0] DIC_A1_CLEAR = 8'h0E;
   localparam logic [7:0] DIC_IRQ_CHAN0 = 8'h20;
   localparam logic [7:0] DIC_LATCH_CFG = 8'h25;
   localparam logic [7:0] DIC_ACTIVATE = 8'h30;
   localparam logic [7:0] DIC_VOLUME = 8'h64;
   localparam logic [7:0] DIC_VOL_CLEAR = 8'h66;
   localparam logic [7:0] DIC_RELOAD_LO = 8'h74;
   localparam logic [7:0] DIC_RELOAD_HI = 8'h76;
   localparam logic [7:0] DIC_CTL1 = 8'h78;
   localparam logic [7:0] DIC_CTL2 = 8'h7A;
   localparam logic [7:0] DIC_ROUTE0 = 8'h90;
   // Field positions.
   localparam int DIC_CTL1_FD = 0;
   localparam int DIC_CTL1_EN = 1;
   localparam int DIC_CTL1_AUTO = 4;
   localparam int DIC_CTL2_MASK = 6;
   localparam int DIC_CTL2_IRQ = 7;
   localparam int DIC_VOL_MASK = 1;
   localparam int DIC_VOL_POLL = 3;
   localparam int DIC_MIDI_MASK = 6;
   localparam int DIC_LATCH_EN = 7;
   // Reset values.
   localparam logic [6:0] DIC_SRC_MASK_RST = 7'h7F;
   // Sources and pins.
   localparam int DIC_NSRC = 7;
   localparam int DIC_NPIN = 5;
   // Timing: clock rate and the DRQ latch timeout.
   localparam int DIC_CLK_HZ = 10000000;
   localparam int DIC_LATCH_MS = 8;
   localparam int DIC_MS_CYCLES = DIC_CLK_HZ / 1000;
   // Interrupt pin bundle: level and output enable per pin.
   typedef struct packed {
      logic [4:0] level;
      logic [4:0] oe;
   } dic_irqpin_s;
   // Activation of the logical devices.
   typedef struct packed {
      logic gp;
      logic modem;
      logic cd;
      logic audio;
   } dic_active_s;
endpackage

/* File: tb/dic_top_assertions.sv */
// Port checks for the duplex DMA and interrupt block.
`timescale 1ns/10ps
module dic_top_assertions import dic_pkg::*; #(
   parameter int MS_CYCLES = DIC_MS_CYCLES,
   parameter int FIFO_DEPTH = 32
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [2:0] drq_raw_in,
   input wire logic sample_tick,
   input wire logic [2:0] drq_out,
   input wire logic [15:0] dac_word_q,
   input wire dic_irqpin_s irq_pins
);
   //======================================================================
   // Bus, interrupt pin, request and converter checks.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_one_wait: assert property ($rose(avs_read || avs_write) |->
      avs_waitrequest ##1 !avs_waitrequest)
      else $error("Bus wait is not one cycle.");
   a_idle_nowait: assert property (!(avs_read || avs_write) |->
      !avs_waitrequest) else $error("Wait raised while idle.");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
      avs_address == 8'h05 |-> avs_readdata == 32'h0)
      else $error("Unmapped read not zero.");
   a_status_top: assert property (
      avs_read && !avs_waitrequest && avs_address == DIC_STATUS
      |-> avs_readdata[31:7] == 25'h0) else $error("Status top bits set.");
   a_level_has_oe: assert property (
      (irq_pins.level & ~irq_pins.oe) == 5'h0)
      else $error("Pin level high while floating.");
   a_drq_pass: assert property (
      (drq_raw_in & 3'h5 & ~drq_out) == 3'h0)
      else $error("Request not passed to pin.");
   a_drq_fall: assert property ($fell(drq_out[0]) |->
      !drq_raw_in[0]) else $error("Request fell while raised.");
   a_dac_on_tick: assert property (!$past(sample_tick) |->
      $stable(dac_word_q)) else $error("Converter word moved off tick.");
endmodule

/* File: tb/dic_isa_host.sv */
// Host DMA model that answers the playback request with bytes.
`timescale 1ns/10ps
module dic_isa_host (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic drq,
   input wire logic slow,
   output logic dack_n,
   output logic [7:0] data,
   output int sent
);
   // Each seen request gets one acknowledge pulse carrying the next byte.
   initial begin
      dack_n = 1'b1;
      data = 8'hFF;
      sent = 0;
      forever begin
         @(posedge sys_clk);
         if (!reset && drq === 1'b1) begin
            repeat (slow ? 5 : 1) @(posedge sys_clk);
            data <= 8'(sent) ^ 8'h5A;
            dack_n <= 1'b0;
            repeat (2) @(posedge sys_clk);
            dack_n <= 1'b1;
            sent <= sent + 1;
            @(posedge sys_clk);
            // One cycle after release the bus shows the inverse of the old byte.
            data <= ~data;
            repeat (4) @(posedge sys_clk);
         end
      end
   end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the duplex DMA and interrupt block.
`timescale 1ns/10ps
module tb_top;
   import dic_pkg::*;
   logic sys_clk = 0, reset = 1, rd = 0, wr = 0, srst = 0, a1e = 0;
   logic vole = 0, midi = 0, cd = 0, mdm = 0, dis = 0, gp = 0, gdrq = 0;
   logic hld = 0, tick = 0, slow = 0, d0n = 1, d2n = 1, hdn, wt, pb;
   logic [7:0] adr = 0, hdat;
   logic [31:0] wd = 0, rdata, q, r;
   logic [23:0] hdr = 0;
   logic [2:0] raw = 0, drq;
   logic [15:0] dac;
   logic [6:0] src, act;
   logic [4:0] lev, oe;
   dic_irqpin_s pins;
   int hsent, base, num_errors = 0, n_checks = 0, seed = 32'h3cf0;
   int rt[7];
   //======================================================================
   // Design, host model and clock.
   dic_top #(.MS_CYCLES(10)) dic_top_i (.sys_clk(sys_clk), .reset(reset),
      .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_readdata(rdata), .avs_waitrequest(wt), .soft_reset(srst),
      .audio1_event(a1e), .vol_button_event(vole), .midi_rx_avail(midi),
      .optical_drive_irq_in(cd), .modem_irq_in(mdm),
      .modem_irq_disable_in(dis), .general_purpose_input(gp),
      .gpi_is_drq(gdrq), .cfg_hdr_load(hld), .cfg_hdr_irq_chan(hdr),
      .drq_raw_in(raw), .dack_n_in({d2n, hdn, d0n}), .isa_data_in(hdat),
      .sample_tick(tick), .drq_out(drq), .dac_word_q(dac), .irq_pins(pins));
   dic_isa_host dic_isa_host_i (.sys_clk(sys_clk), .reset(reset),
      .drq(drq[1]), .slow(slow), .dack_n(hdn), .data(hdat), .sent(hsent));
   always #50 sys_clk = ~sys_clk;
   //======================================================================
   // Shared tasks.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [7:0] d);
      adr <= a;
      wd <= {24'h0, d};
      wr <= w;
      rd <= !w;
      do begin
         @(posedge sys_clk);
      end while (wt !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h0);
      chk(q, exp);
   endtask
   task automatic tk;
      tick <= 1'b1;
      cyc(1);
      tick <= 1'b0;
      cyc(1);
   endtask
   function automatic logic [15:0] wrd(input int n);
      return {8'(n + 1) ^ 8'h5A, 8'(n) ^ 8'h5A};
   endfunction
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog cuts a hung run short.
   initial begin
      #(100 * 60000);
      num_errors++;
      wrap_up();
   end
   //======================================================================
   // Main sequence.
   initial begin
      cyc(10);
      reset <= 1'b0;
      cyc(2);
      rdchk(DIC_SRC_MASK, 32'h7F);
      rdchk(8'h05, 32'h0);
      hdr <= 24'h0B0705;
      hld <= 1'b1;
      cyc(1);
      hld <= 1'b0;
      for (int i = 0; i < 3; i++)
         rdchk(DIC_IRQ_CHAN0 + 8'(i), 32'(hdr[8*i +: 8]));
      a1e <= 1'b1;
      cyc(1);
      a1e <= 1'b0;
      rdchk(DIC_A1_POLL, 32'h1);
      rdchk(DIC_A1_CLEAR, 32'h1);
      rdchk(DIC_A1_POLL, 32'h0);
      a1e <= 1'b1;
      cyc(1);
      a1e <= 1'b0;
      srst <= 1'b1;
      cyc(1);
      srst <= 1'b0;
      rdchk(DIC_A1_POLL, 32'h0);
      vole <= 1'b1;
      cyc(1);
      vole <= 1'b0;
      rdchk(DIC_VOLUME, 32'h8);
      bus(1'b1, DIC_VOL_CLEAR, 8'h0);
      rdchk(DIC_VOLUME, 32'h0);
      $display("test registers done");
      bus(1'b1, DIC_LATCH_CFG, 8'h80);
      raw <= 3'b101;
      cyc(1);
      raw <= 3'b000;
      cyc(20);
      chk(32'(drq), 32'h5);
      d0n <= 1'b0;
      cyc(2);
      d0n <= 1'b1;
      cyc(6);
      chk(32'(drq), 32'h4);
      cyc(40);
      chk(32'(drq), 32'h4);
      cyc(40);
      chk(32'(drq), 32'h0);
      bus(1'b1, DIC_LATCH_CFG, 8'h00);
      raw <= 3'b001;
      cyc(1);
      raw <= 3'b000;
      cyc(2);
      chk(32'(drq), 32'h0);
      $display("test latch done");
      bus(1'b1, DIC_RELOAD_LO, 8'hB0);
      bus(1'b1, DIC_RELOAD_HI, 8'hFF);
      bus(1'b1, DIC_CTL2, 8'h00);
      bus(1'b1, DIC_CTL1, 8'h03);
      cyc(1500);
      chk(hsent, 64);
      for (int k = 0; k < 41; k++) begin
         tk();
         chk(dac, k < 40 ? wrd(2 * k) : 16'h0);
         cyc(40);
      end
      chk(hsent, 80);
      rdchk(DIC_CTL2, 32'h80);
      bus(1'b1, DIC_RELOAD_HI, 8'hFF);
      slow <= 1'b1;
      cyc(1500);
      tk();
      chk(dac, wrd(80));
      cyc(100);
      bus(1'b1, DIC_CTL1, 8'h00);
      tk();
      chk(dac, wrd(80));
      bus(1'b1, DIC_RELOAD_LO, 8'hFE);
      bus(1'b1, DIC_RELOAD_HI, 8'hFF);
      bus(1'b1, DIC_CTL2, 8'h00);
      base = hsent;
      bus(1'b1, DIC_CTL1, 8'h13);
      cyc(1500);
      chk(hsent - base, 64);
      rdchk(DIC_CTL2, 32'h80);
      tk();
      chk(dac, wrd(base));
      bus(1'b1, DIC_CTL1, 8'h00);
      pb = 1'b1;
      $display("test playback done");
      for (int it = 0; it < 40; it++) begin
         for (int s = 0; s < 7; s++) begin
            rt[s] = $unsigned($random(seed)) % 6;
            bus(1'b1, DIC_ROUTE0 + 8'(s), 8'(rt[s]));
         end
         r = $random(seed);
         bus(1'b0, DIC_A1_CLEAR, 8'h0);
         bus(1'b1, DIC_VOL_CLEAR, 8'h0);
         bus(1'b1, DIC_SRC_MASK, {1'b0, r[6:0]});
         bus(1'b1, DIC_ACTIVATE, {4'h0, r[10:7]});
         bus(1'b1, DIC_VOLUME, {1'b0, r[11], 4'h0, r[12], 1'b0});
         bus(1'b1, DIC_CTL2, {r[13], r[14], 6'h0});
         pb = pb & r[13];
         {midi, cd, mdm, dis, gp, gdrq} <= r[20:15];
         a1e <= r[21];
         vole <= r[22];
         cyc(1);
         a1e <= 1'b0;
         vole <= 1'b0;
         cyc(6);
         src = {r[16] & ~r[15], r[18] & ~r[17], r[19], r[20] & r[11],
            r[22] & r[12], pb & r[14], r[21]};
         act = {r[10], r[9] & ~r[17], r[8], {4{r[7]}}};
         lev = 5'h0;
         oe = 5'h0;
         for (int s = 0; s < 7; s++) begin
            if (rt[s] > 0) begin
               lev[rt[s] - 1] |= src[s] & r[s] & act[s];
               oe[rt[s] - 1] |= act[s];
            end
         end
         chk(32'(pins), 32'({lev, oe}));
         rdchk(DIC_STATUS, 32'(src));
      end
      $display("test routing done");
      wrap_up();
   end
endmodule
bind dic_top dic_top_assertions #(.MS_CYCLES(MS_CYCLES),
   .FIFO_DEPTH(FIFO_DEPTH)) dic_top_assertions_i (.sys_clk(sys_clk),
   .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .drq_raw_in(drq_raw_in),
   .sample_tick(sample_tick), .drq_out(drq_out),
   .dac_word_q(dac_word_q), .irq_pins(irq_pins));
